// *** common/sle_pkg.sv ***
// Purpose: shared constants for the serial link event flag block
// Assumes: byte-wide register port, register offsets as printed
// Notes:   all register state resets to zero
package sle_pkg;

    // link banks and alignment data
    localparam int SLE_NUM_LINKS  = 2;
    localparam int SLE_ILAS_BYTES = 14;

    // register offsets
    localparam logic [11:0] SLE_OFS_LINK_PAGE  = 12'h300;
    localparam logic [11:0] SLE_OFS_ILAS_FIRST = 12'h450;
    localparam logic [11:0] SLE_OFS_ILAS_LAST  = 12'h45d;
    localparam logic [11:0] SLE_OFS_EN_A       = 12'h4b8;
    localparam logic [11:0] SLE_OFS_EN_B       = 12'h4b9;
    localparam logic [11:0] SLE_OFS_ST_A       = 12'h4ba;
    localparam logic [11:0] SLE_OFS_ST_B       = 12'h4bb;
    localparam logic [11:0] SLE_OFS_PIN_SEL    = 12'h4bc;

    // event bit positions in the first enable and first status register
    localparam int SLE_BIT_BAD_DISPARITY = 7;
    localparam int SLE_BIT_NOT_IN_TABLE  = 6;
    localparam int SLE_BIT_UNEXP_CTRL    = 5;
    localparam int SLE_BIT_DESKEW        = 4;
    localparam int SLE_BIT_LANE_SYNC     = 3;
    localparam int SLE_BIT_CHECKSUM      = 2;
    localparam int SLE_BIT_FRAME_SYNC    = 1;
    localparam int SLE_BIT_CODE_GROUP    = 0;

    // single-bit registers
    localparam int SLE_BIT_CFG_MISMATCH  = 0;
    localparam int SLE_BIT_PIN_SELECT    = 0;

    // values after reset and for unmapped reads
    localparam logic [7:0] SLE_RESET_BYTE = 8'h00;
    localparam logic [6:0] SLE_RSVD_BITS  = 7'h00;

endpackage

// *** tb/sle_link_tx.sv ***
// Purpose: stand-in for the link transmitter, events and lane-0 bytes
// Assumes: two links, bytes sent in index order
// Notes:   data line inverts between frames so stale bytes never look valid
`timescale 1ns/1ps
module sle_link_tx (
    input  wire logic        CLK,
    output logic      [15:0] LINK_EVENTS,
    output logic      [1:0]  ILAS_VALID,
    output logic      [7:0]  ILAS_IDX,
    output logic      [15:0] ILAS_DATA
);
    initial begin
        LINK_EVENTS = 16'h0000;
        ILAS_VALID  = 2'h0;
        ILAS_IDX    = 8'h00;
        ILAS_DATA   = 16'h0000;
    end

    task automatic pulse(input int l, input logic [7:0] ev);
        @(posedge CLK);
        LINK_EVENTS[l*8 +: 8] <= ev;
        @(posedge CLK);
        LINK_EVENTS <= 16'h0000;
    endtask

    // checksum byte last, as the transmitter sends it
    task automatic frame(input int l, input logic [13:0][7:0] b);
        for (int i = 0; i < 14; i++) begin
            @(posedge CLK);
            ILAS_VALID[l]         <= 1'b1;
            ILAS_IDX[l*4 +: 4]    <= 4'(i);
            ILAS_DATA[l*8 +: 8]   <= b[i];
        end
        @(posedge CLK);
        ILAS_VALID <= 2'h0;
        ILAS_DATA  <= ~ILAS_DATA;
    endtask
endmodule // sle_link_tx

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the link event flag block
// Assumes: two links, model kept in plain integers
// Notes:   alignment checks run on link 0 only
`timescale 1ns/1ps
module testbench;
    logic             CLK, RST, REG_WR, REG_RD, REG_RVALID;
    logic             IRQ_OUT0, IRQ_OUT1;
    logic [11:0]      REG_ADDR;
    logic [7:0]       REG_WDATA, REG_RDATA, ILAS_IDX;
    logic [15:0]      LINK_EVENTS, ILAS_DATA;
    logic [1:0]       ILAS_VALID;
    int               n_errors = 0;
    int               tests_run = 0;
    int               en_a[2], st_a[2], st_b[2], pin;
    logic [13:0][7:0] prog;

    sle_event_flags #(.NUM_LINKS(2), .NBYTES(14)) u_dut (
        .CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .REG_RVALID(REG_RVALID), .LINK_EVENTS(LINK_EVENTS),
        .ILAS_VALID(ILAS_VALID), .ILAS_IDX(ILAS_IDX),
        .ILAS_DATA(ILAS_DATA), .IRQ_OUT0(IRQ_OUT0), .IRQ_OUT1(IRQ_OUT1));
    sle_link_tx u_tx (
        .CLK(CLK), .LINK_EVENTS(LINK_EVENTS), .ILAS_VALID(ILAS_VALID),
        .ILAS_IDX(ILAS_IDX), .ILAS_DATA(ILAS_DATA));

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h want %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge CLK);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge CLK);
        REG_WR    <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge CLK);
        REG_RD   <= 1'b0;
        #1;
        chk({7'h00, REG_RVALID}, 8'h01, "read answer");
        chk(REG_RDATA, exp, "read data");
    endtask

    // interrupt is the or of every flag of every link, on the chosen pin
    task automatic chk_irq();
        logic any;
        any = (st_a[0] | st_a[1] | st_b[0] | st_b[1]) != 0;
        #1;
        chk({6'h00, IRQ_OUT1, IRQ_OUT0},
            {6'h00, any & pin[0], any & ~pin[0]}, "irq pins");
    endtask

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    initial begin
        repeat (20000) @(posedge CLK);
        n_errors++;
        complete_run();
    end

    initial begin
        logic [7:0]       e;
        logic [13:0][7:0] f;
        logic [7:0]       g;
        int               s, l, cks, mis;
        RST = 1'b1;
        REG_ADDR = 12'h000;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_WDATA = 8'h00;
        pin = 0;
        st_a = '{0, 0};
        st_b = '{0, 0};
        e = 8'($urandom(32'h29dc));
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        rd(12'h4b8, 8'h00);
        rd(12'h4b9, 8'h00);
        rd(12'h4ba, 8'h00);
        rd(12'h4bc, 8'h00);
        rd(12'h123, 8'h00);
        for (l = 0; l < 2; l++) begin
            en_a[l] = $urandom_range(0, 255) | 8'h05;
            wr(12'h300, 8'(l));
            wr(12'h4b8, 8'(en_a[l]));
            wr(12'h4b9, 8'hff);
        end
        for (l = 0; l < 2; l++) begin
            wr(12'h300, 8'(l));
            rd(12'h4b8, 8'(en_a[l]));
            rd(12'h4b9, 8'h01);
        end
        // bit 2 of the event bus is unused: checksum comes from the frame
        repeat (10) begin
            l = $urandom_range(0, 1);
            e = 8'($urandom);
            u_tx.pulse(l, e);
            st_a[l] = st_a[l] | (e & en_a[l] & 8'hfb);
            chk_irq();
        end
        for (l = 0; l < 2; l++) begin
            wr(12'h300, 8'(l));
            rd(12'h4ba, 8'(st_a[l]));
            wr(12'h4ba, 8'h00);
            st_a[l] = 0;
        end
        chk_irq();
        wr(12'h4bc, 8'h01);
        pin = 1;
        u_tx.pulse(1, 8'h01);
        st_a[1] = 1;
        chk_irq();
        wr(12'h4ba, 8'h00);
        st_a[1] = 0;
        wr(12'h300, 8'h00);
        s = 0;
        for (int i = 0; i < 13; i++) begin
            prog[i] = 8'($urandom);
            s += prog[i];
        end
        g = 8'(s);
        prog[13] = g;
        for (int i = 0; i < 14; i++)
            wr(12'h450 + 12'(i), prog[i]);
        for (int i = 0; i < 14; i++)
            rd(12'h450 + 12'(i), prog[i]);
        // good, field bad, sent sum bad, programmed sum differs, good again
        for (int c = 0; c < 5; c++) begin
            f = prog;
            f[13] = g;
            if (c == 1) begin
                f[3] = f[3] + 8'h01;
                f[13] = f[13] + 8'h01;
            end
            if (c == 2)
                f[13] = g + 8'h01;
            if (c >= 2) begin
                prog[13] = (c == 3) ? g + 8'h02 : f[13];
                wr(12'h45d, prog[13]);
            end
            s = 0;
            for (int i = 0; i < 13; i++)
                s += f[i];
            cks = f[13] != 8'(s);
            mis = f != prog;
            u_tx.frame(0, f);
            repeat (2) @(posedge CLK);
            st_a[0] = cks ? 4 : 0;
            st_b[0] = mis;
            chk_irq();
            rd(12'h4ba, 8'(st_a[0]));
            rd(12'h4bb, 8'(st_b[0]));
            wr(12'h4ba, 8'h00);
            wr(12'h4bb, 8'h00);
            st_a[0] = 0;
            st_b[0] = 0;
        end
        // a clear and an event on the same edge: the event wins
        fork
            wr(12'h4ba, 8'h00);
            u_tx.pulse(0, 8'h01);
        join
        st_a[0] = 1;
        chk_irq();
        rd(12'h4ba, 8'h01);
        wr(12'h4ba, 8'h00);
        st_a[0] = 0;
        chk_irq();
        // a reset in mid-run clears enables, flags, page and pin choice
        u_tx.pulse(1, 8'h01);
        st_a[1] = 1;
        chk_irq();
        @(posedge CLK);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        st_a = '{0, 0};
        pin = 0;
        rd(12'h300, 8'h00);
        rd(12'h4b8, 8'h00);
        rd(12'h4ba, 8'h00);
        rd(12'h4bc, 8'h00);
        chk_irq();
        complete_run();
    end
endmodule // testbench

// *** verilog/sle_event_flags.sv ***
// Purpose: per-link event enables, sticky status and interrupt routing
// Assumes: register port already decoded from the serial control port
// Notes:   reads answer one cycle after the strobe; set beats clear
`timescale 1ns/1ps

module sle_event_flags #(
    parameter int NUM_LINKS = sle_pkg::SLE_NUM_LINKS,
    parameter int NBYTES    = sle_pkg::SLE_ILAS_BYTES
) (
    input  wire logic                   CLK,
    input  wire logic                   RST,
    input  wire logic [11:0]            REG_ADDR,
    input  wire logic                   REG_WR,
    input  wire logic                   REG_RD,
    input  wire logic [7:0]             REG_WDATA,
    output logic      [7:0]             REG_RDATA,
    output logic                        REG_RVALID,
    input  wire logic [NUM_LINKS*8-1:0] LINK_EVENTS,
    input  wire logic [NUM_LINKS-1:0]   ILAS_VALID,
    input  wire logic [NUM_LINKS*4-1:0] ILAS_IDX,
    input  wire logic [NUM_LINKS*8-1:0] ILAS_DATA,
    output logic                        IRQ_OUT0,
    output logic                        IRQ_OUT1
);
    localparam int PW = (NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1;

    typedef struct packed {
        logic [PW-1:0]                         page;
        logic [NUM_LINKS-1:0][7:0]             en_a;
        logic [NUM_LINKS-1:0]                  en_b;
        logic [NUM_LINKS-1:0][7:0]             st_a;
        logic [NUM_LINKS-1:0]                  st_b;
        logic                                  pin_sel;
        logic [NUM_LINKS-1:0][NBYTES-1:0][7:0] exp_cfg;
        logic [7:0]                            rdata;
        logic                                  rvalid;
        logic                                  irq0;
        logic                                  irq1;
    } sle_state_t;

    sle_state_t             s;
    sle_state_t             next_s;
    logic [NUM_LINKS-1:0]   cks_err;
    logic [NUM_LINKS-1:0]   cfg_err;

    // one checker per link, fed from that link's lane 0 only
    for (genvar l = 0; l < NUM_LINKS; l++) begin : g_chk
        sle_ilas_check #(
            .NBYTES (NBYTES)
        ) u_chk (
            .clk     (CLK),
            .rst     (RST),
            .valid   (ILAS_VALID[l]),
            .idx     (ILAS_IDX[l*4 +: 4]),
            .data    (ILAS_DATA[l*8 +: 8]),
            .exp_cfg (s.exp_cfg[l]),
            .cks_err (cks_err[l]),
            .cfg_err (cfg_err[l])
        );
    end

    always_comb begin
        logic [11:0] ofs;
        logic [3:0]  bidx;
        logic [7:0]  ev;
        logic        any;
        ofs           = REG_ADDR - sle_pkg::SLE_OFS_ILAS_FIRST;
        bidx          = ofs[3:0];
        ev            = 8'h00;
        any           = 1'b0;
        next_s        = s;
        next_s.rvalid = REG_RD;
        next_s.rdata  = sle_pkg::SLE_RESET_BYTE;

        // enable, status and expected-byte writes land in the bank the page selects; page and pin select are shared
        if (REG_WR) begin
            unique case (REG_ADDR)
                sle_pkg::SLE_OFS_LINK_PAGE: begin
                    next_s.page = REG_WDATA[PW-1:0];
                end
                sle_pkg::SLE_OFS_EN_A: begin
                    next_s.en_a[s.page] = REG_WDATA;
                end
                sle_pkg::SLE_OFS_EN_B: begin
                    next_s.en_b[s.page] =
                        REG_WDATA[sle_pkg::SLE_BIT_CFG_MISMATCH];
                end
                sle_pkg::SLE_OFS_ST_A: begin
                    next_s.st_a[s.page] = REG_WDATA;
                end
                sle_pkg::SLE_OFS_ST_B: begin
                    next_s.st_b[s.page] =
                        REG_WDATA[sle_pkg::SLE_BIT_CFG_MISMATCH];
                end
                sle_pkg::SLE_OFS_PIN_SEL: begin
                    next_s.pin_sel =
                        REG_WDATA[sle_pkg::SLE_BIT_PIN_SELECT];
                end
                default: begin
                    if (REG_ADDR >= sle_pkg::SLE_OFS_ILAS_FIRST &&
                        REG_ADDR <= sle_pkg::SLE_OFS_ILAS_LAST) begin
                        next_s.exp_cfg[s.page][bidx] = REG_WDATA;
                    end
                end
            endcase
        end

        // hardware sets are applied after the write so they win
        for (int l = 0; l < NUM_LINKS; l++) begin
            ev = LINK_EVENTS[l*8 +: 8];
            // external checksum line is unused: only the lane checker counts
            ev[sle_pkg::SLE_BIT_CHECKSUM] = cks_err[l];
            next_s.st_a[l] = next_s.st_a[l] | (ev & s.en_a[l]);
            next_s.st_b[l] = next_s.st_b[l] |
                             (cfg_err[l] & s.en_b[l]);
        end

        any         = (|next_s.st_a) | (|next_s.st_b);
        next_s.irq0 = any & ~next_s.pin_sel;
        next_s.irq1 = any & next_s.pin_sel;

        if (REG_RD) begin
            unique case (REG_ADDR)
                sle_pkg::SLE_OFS_LINK_PAGE: begin
                    next_s.rdata = 8'(s.page);
                end
                sle_pkg::SLE_OFS_EN_A: begin
                    next_s.rdata = s.en_a[s.page];
                end
                sle_pkg::SLE_OFS_EN_B: begin
                    next_s.rdata = {sle_pkg::SLE_RSVD_BITS, s.en_b[s.page]};
                end
                sle_pkg::SLE_OFS_ST_A: begin
                    next_s.rdata = s.st_a[s.page];
                end
                sle_pkg::SLE_OFS_ST_B: begin
                    next_s.rdata = {sle_pkg::SLE_RSVD_BITS, s.st_b[s.page]};
                end
                sle_pkg::SLE_OFS_PIN_SEL: begin
                    next_s.rdata = {sle_pkg::SLE_RSVD_BITS, s.pin_sel};
                end
                default: begin
                    if (REG_ADDR >= sle_pkg::SLE_OFS_ILAS_FIRST &&
                        REG_ADDR <= sle_pkg::SLE_OFS_ILAS_LAST) begin
                        next_s.rdata = s.exp_cfg[s.page][bidx];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign REG_RDATA  = s.rdata;
    assign REG_RVALID = s.rvalid;
    assign IRQ_OUT0   = s.irq0;
    assign IRQ_OUT1   = s.irq1;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    localparam int TOP = NUM_LINKS - 1;

    cks_flag_a: assert property (
        cks_err[0] && s.en_a[0][sle_pkg::SLE_BIT_CHECKSUM]
        |=> s.st_a[0][sle_pkg::SLE_BIT_CHECKSUM]
    ) else $error("checksum flag not set");

    cfg_cause_a: assert property (
        $rose(s.st_b[0])
        |-> $past(cfg_err[0] && s.en_b[0]) || $past(REG_WR)
    ) else $error("mismatch flag set without cause");

    bank_keep_a: assert property (
        REG_WR && REG_ADDR == sle_pkg::SLE_OFS_EN_A && s.page != PW'(TOP)
        |=> $stable(s.en_a[TOP])
    ) else $error("write leaked into other bank");

    top_flag_a: assert property (
        LINK_EVENTS[sle_pkg::SLE_BIT_BAD_DISPARITY] &&
        s.en_a[0][sle_pkg::SLE_BIT_BAD_DISPARITY]
        |=> s.st_a[0][sle_pkg::SLE_BIT_BAD_DISPARITY] ##1
            s.st_a[0][sle_pkg::SLE_BIT_BAD_DISPARITY] || $past(REG_WR)
    ) else $error("disparity flag not sticky");

    masked_event_a: assert property (
        LINK_EVENTS[sle_pkg::SLE_BIT_FRAME_SYNC] &&
        !s.en_a[0][sle_pkg::SLE_BIT_FRAME_SYNC] &&
        !s.st_a[0][sle_pkg::SLE_BIT_FRAME_SYNC] && !REG_WR
        |=> !s.st_a[0][sle_pkg::SLE_BIT_FRAME_SYNC]
    ) else $error("disabled event set a flag");

    enable_write_a: assert property (
        REG_WR && REG_ADDR == sle_pkg::SLE_OFS_EN_A
        |=> s.en_a[$past(s.page)] == $past(REG_WDATA)
    ) else $error("enable write lost");

    reset_clear_a: assert property (
        @(posedge CLK) disable iff (1'b0)
        RST |=> s.en_a == '0 && s.en_b == '0 && !IRQ_OUT0
    ) else $error("enables not cleared by reset");

    pin_route_a: assert property (
        (IRQ_OUT1 |-> s.pin_sel) and (IRQ_OUT0 |-> !s.pin_sel)
    ) else $error("interrupt on unselected pin");

    irq_raise_a: assert property (
        LINK_EVENTS[sle_pkg::SLE_BIT_CODE_GROUP] &&
        s.en_a[0][sle_pkg::SLE_BIT_CODE_GROUP]
        |=> IRQ_OUT0 || IRQ_OUT1
    ) else $error("interrupt not raised");

    irq_quiet_a: assert property (
        s.st_a == '0 && s.st_b == '0 |-> !IRQ_OUT0 && !IRQ_OUT1
    ) else $error("interrupt without flag");

    read_turn_a: assert property (
        REG_RD |=> REG_RVALID
    ) else $error("read not answered");

    // the read port idles at zero between answers
    read_idle_a: assert property (
        !REG_RD |=> REG_RDATA == 8'h00 && !REG_RVALID
    ) else $error("read port not idle");

    read_status_a: assert property (
        REG_RD && REG_ADDR == sle_pkg::SLE_OFS_ST_A
        |=> REG_RDATA == $past(s.st_a[s.page])
    ) else $error("status read wrong");

    status_write_a: assert property (
        REG_WR && REG_ADDR == sle_pkg::SLE_OFS_ST_A && s.page == '0 &&
        LINK_EVENTS[7:0] == 8'h00 && !cks_err[0]
        |=> s.st_a[0] == $past(REG_WDATA)
    ) else $error("status write not stored");

    // a clear that meets an event must not lose it
    set_wins_a: assert property (
        REG_WR && REG_ADDR == sle_pkg::SLE_OFS_ST_A && s.page == '0 &&
        LINK_EVENTS[sle_pkg::SLE_BIT_CODE_GROUP] &&
        s.en_a[0][sle_pkg::SLE_BIT_CODE_GROUP]
        |=> s.st_a[0][sle_pkg::SLE_BIT_CODE_GROUP]
    ) else $error("clear beat a same-cycle event");

    page_write_a: assert property (
        REG_WR && REG_ADDR == sle_pkg::SLE_OFS_LINK_PAGE
        |=> s.page == $past(REG_WDATA[PW-1:0])
    ) else $error("page write lost");

    exp_write_a: assert property (
        REG_WR && REG_ADDR == sle_pkg::SLE_OFS_ILAS_FIRST
        |=> s.exp_cfg[$past(s.page)][0] == $past(REG_WDATA)
    ) else $error("expected alignment byte lost");

    // the outside checksum line must never reach the flag
    cks_ignore_a: assert property (
        LINK_EVENTS[sle_pkg::SLE_BIT_CHECKSUM] && !cks_err[0] &&
        !s.st_a[0][sle_pkg::SLE_BIT_CHECKSUM] && !REG_WR
        |=> !s.st_a[0][sle_pkg::SLE_BIT_CHECKSUM]
    ) else $error("outside checksum line set the flag");

    cfg_flag_a: assert property (
        cfg_err[0] && s.en_b[0] |=> s.st_b[0]
    ) else $error("mismatch flag not set");

    cfg_idle_a: assert property (
        !cfg_err[0] && !s.st_b[0] && !REG_WR |=> !s.st_b[0]
    ) else $error("mismatch flag set with no mismatch");

    // pins and flags are registered together, so they agree every cycle
    irq_route_a: assert property (
        s.st_a != '0 || s.st_b != '0
        |-> (s.pin_sel ? IRQ_OUT1 : IRQ_OUT0)
    ) else $error("flag set but selected pin low");

    cks_seen_c: cover property (
        cks_err[0] && s.en_a[0][sle_pkg::SLE_BIT_CHECKSUM]
    );
    cfg_seen_c: cover property (cfg_err[0] && s.en_b[0]);
    pin1_seen_c: cover property ($rose(IRQ_OUT1));
    clear_race_c: cover property (
        REG_WR && REG_ADDR == sle_pkg::SLE_OFS_ST_A && |LINK_EVENTS
    );
    bank1_seen_c: cover property (REG_WR && s.page != '0);

endmodule // sle_event_flags

// *** verilog/sle_ilas_check.sv ***
// Purpose: checks one lane's received alignment sequence
// Assumes: bytes arrive tagged with their index, checksum byte last
// Notes:   checksum is the byte-wise sum mod 256 of the fields before it
`timescale 1ns/1ps
module sle_ilas_check #(
    parameter int NBYTES = sle_pkg::SLE_ILAS_BYTES
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   valid,
    input  wire logic [3:0]             idx,
    input  wire logic [7:0]             data,
    input  wire logic [NBYTES-1:0][7:0] exp_cfg,
    output logic                        cks_err,
    output logic                        cfg_err
);
    localparam logic [3:0] LAST = 4'(NBYTES - 1);

    typedef struct packed {
        logic [7:0] sum;
        logic       diff;
        logic       cks_err;
        logic       cfg_err;
    } sle_chk_t;

    sle_chk_t s;
    sle_chk_t next_s;

    always_comb begin
        next_s         = s;
        next_s.cks_err = 1'b0;
        next_s.cfg_err = 1'b0;
        if (valid) begin
            if (idx == 4'h0) begin
                next_s.sum  = data;
                next_s.diff = (data != exp_cfg[0]);
            end else if (idx < LAST) begin
                next_s.sum  = s.sum + data;
                next_s.diff = s.diff | (data != exp_cfg[idx]);
            end else if (idx == LAST) begin
                // programmed checksum never enters this compare
                next_s.cks_err = (data != s.sum);
                next_s.cfg_err = s.diff | (data != exp_cfg[LAST]);
                next_s.sum     = 8'h00;
                next_s.diff    = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign cks_err = s.cks_err;
    assign cfg_err = s.cfg_err;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    cks_good_a: assert property (
        valid && idx == LAST && data == s.sum |=> !cks_err
    ) else $error("checksum flagged though sums agree");

    cks_bad_a: assert property (
        valid && idx == LAST && data != s.sum |=> cks_err
    ) else $error("checksum error missed");

    cfg_field_a: assert property (
        valid && idx == LAST && s.diff |=> cfg_err
    ) else $error("field mismatch not reported");

    cfg_cks_a: assert property (
        valid && idx == LAST && data != exp_cfg[LAST] |=> cfg_err
    ) else $error("checksum field mismatch not reported");

    cfg_match_a: assert property (
        valid && idx == LAST && !s.diff && data == exp_cfg[LAST]
        |=> !cfg_err
    ) else $error("mismatch flagged on matching data");

endmodule // sle_ilas_check
